// File: rtl/vrl_lane_ctrl.sv
// Control logic of a four-lane video retimer: power states, mode crossover, lane routing,
// equalizer and termination choice, clock ratio flag, error counters and test pattern.
// Assumes strap and link pins are asynchronous; host config ports are on i_clk.
`timescale 1ns/10ps

module vrl_lane_ctrl
	import vrl_pkg::*;
(
	// Clock, reset, enable
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_ce,
	// Pins and straps (asynchronous)
	input  wire logic               i_dev_enable,
	input  wire logic               i_hpd,
	input  wire logic               i_swap_polarity_strap,
	input  wire logic               i_signal_detect_enable,
	input  wire logic               i_host_cfg_en,
	input  wire logic               i_link_clk,
	input  wire logic [1:0]         i_equalizer_select_strap,
	input  wire logic [1:0]         i_output_termination_select,
	input  wire logic [1:0]         i_bus_address_straps,
	// Host configuration (synchronous)
	input  wire logic               i_cfg_we,
	input  wire logic [7:0]         i_cfg_wdata,
	input  wire logic               i_ratio_set,
	input  wire logic               i_ratio_clr,
	input  wire logic [2:0]         i_lane_err,
	input  wire logic               i_err_clr,
	// Status and control outputs
	output logic [3:0]              o_state,
	output logic                    o_link_oe_n,
	output logic                    o_power_down,
	output logic                    o_standby,
	output logic                    o_retimer,
	output logic [1:0]              o_term_sel,
	output logic [1:0]              o_eq_mode,
	output logic [7:0]              o_lane_src,
	output logic                    o_pol_inv,
	output logic                    o_ddc_fast,
	output logic [1:0]              o_bus_addr,
	output logic                    o_ratio_flag,
	output logic                    o_clk_div40,
	output logic [23:0]             o_err_cnt,
	output logic                    o_prbs_active,
	output logic [2:0]              o_prbs_data
);
	import vrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic [SY_W-1:0] sy_meta;
	logic [SY_W-1:0] sy;
	logic            lclk_d;
	wire  [SY_W-1:0] sy_in = {i_bus_address_straps, i_output_termination_select,
	                          i_equalizer_select_strap, i_link_clk, i_host_cfg_en,
	                          i_signal_detect_enable, i_swap_polarity_strap, i_hpd, i_dev_enable};

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sy_meta <= SY_RST;
			sy      <= SY_RST;
			lclk_d  <= 1'b0;
		end else if (i_ce) begin
			sy_meta <= sy_in;
			sy      <= sy_meta;
			lclk_d  <= sy[SY_LCLK];
		end
	end

	wire       en_s      = sy[SY_EN];
	wire       hpd_s     = sy[SY_HPD];
	wire       lclk_rise = sy[SY_LCLK] & ~lclk_d;
	wire [1:0] eq_strap  = sy[SY_EQ+1:SY_EQ];
	wire [1:0] tm_strap  = sy[SY_TERM+1:SY_TERM];

	////////////////////////////////////////////////////////////////////////////////
	// Rate detect from link clock period

	logic [7:0] per_cnt;
	logic [7:0] period;
	logic       clk_valid;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			per_cnt   <= 8'h00;
			period    <= PER_SAT;
			clk_valid <= 1'b0;
		end else if (i_ce) begin
			if (lclk_rise) begin
				per_cnt   <= 8'h01;
				period    <= per_cnt;
				clk_valid <= 1'b1;
			end else begin
				if (per_cnt != PER_SAT)
					per_cnt <= per_cnt + 8'h01;
				if (per_cnt >= 8'(SIG_TIMEOUT_CYC))
					clk_valid <= 1'b0;
			end
		end
	end

	// Shorter period means higher rate; no clock counts as low rate
	wire retimer_w = clk_valid && (period <= RETIMER_PER_MAX);                  // RL1

	////////////////////////////////////////////////////////////////////////////////
	// Host configuration, wiped while disabled

	logic [7:0] cfg;
	logic [1:0] bus_addr;
	vrl_state_t state;
	vrl_state_t next_state;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg      <= CFG_RST;
			bus_addr <= 2'h0;
		end else if (i_ce) begin
			if (!en_s)
				cfg <= CFG_RST;                                                 // RL3
			else if (i_cfg_we && sy[SY_HOSTCFG])
				cfg <= i_cfg_wdata;
			// Address straps are only trusted as the device comes out of disable
			if (en_s && (state == ST_OFF))
				bus_addr <= sy[SY_ADDR+1:SY_ADDR];                              // RL8
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power state machine

	wire pd_req      = !hpd_s || cfg[CFG_PD];                                    // RL2
	wire sigdet_on   = sy[SY_SIGDET] || cfg[CFG_SIGDET];                         // RL23
	wire standby_req = sigdet_on && !clk_valid;                                  // RL6

	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF:     next_state = ST_DOWN;
			ST_DOWN:    if (!pd_req) begin                                      // RL24
				next_state = standby_req ? ST_STANDBY : ST_ACTIVE;
			end
			ST_STANDBY: if (pd_req) begin
				next_state = ST_DOWN;
			end else if (!standby_req) begin
				next_state = ST_ACTIVE;
			end
			ST_ACTIVE:  if (pd_req) begin
				next_state = ST_DOWN;
			end else if (standby_req) begin
				next_state = ST_STANDBY;
			end
			default:    next_state = ST_OFF;
		endcase
		if (!en_s)
			next_state = ST_OFF;                                                // RL2
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			state <= ST_OFF;
		else if (i_ce)
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock ratio flag

	logic ratio;
	wire  live        = (state != ST_OFF);
	// Only power transitions and an explicit write clear it; reads have no path here
	wire  ratio_clear = (state == ST_OFF) || (state == ST_DOWN) || i_ratio_clr;  // RL4 RL5
	// A set in the same cycle as a clear wins, except in ST_OFF where sets are ignored
	wire  next_ratio  = (i_ratio_set && live) ? 1'b1 : (ratio_clear ? 1'b0 : ratio);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			ratio <= 1'b0;
		else if (i_ce)
			ratio <= next_ratio;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lane routing, polarity, equalizer, termination

	wire swap_on = !sy[SY_SWAP] || cfg[CFG_SWAP];                                // RL12
	// Polarity shares the strap with swap; both may act together in retimer operation
	wire pol_req = sy[SY_SWAP] || cfg[CFG_POL];
	wire next_pol = live && retimer_w && pol_req;                                // RL14 RL15 RL16
	// Routing selects input pins; the equalizer of each input pin moves with it
	wire [7:0] next_src = (live && swap_on) ? MAP_SWAP : MAP_NORMAL;             // RL11 RL13

	logic [1:0] eq_raw;
	logic [1:0] next_eq;
	logic [1:0] next_term;

	always_comb begin
		if (sy[SY_HOSTCFG] && cfg[CFG_EQ_HOST])
			eq_raw = cfg[CFG_EQ_ADAPT] ? EQ_ADAPTIVE : EQ_HOST_FIXED;
		else if (eq_strap == STRAP_HIGH)
			eq_raw = EQ_FIXED_14DB;                                             // RL22
		else if (eq_strap == STRAP_LOW)
			eq_raw = EQ_FIXED_7P5DB;
		else
			eq_raw = EQ_ADAPTIVE;
		// Adaptive needs the recovered clock, so redriver falls back to fixed gain
		next_eq = (eq_raw == EQ_ADAPTIVE && !retimer_w) ? EQ_FIXED_14DB : eq_raw; // RL9
	end

	always_comb begin
		if (tm_strap == STRAP_HIGH)
			next_term = TERM_NONE;
		else if (tm_strap == STRAP_LOW)
			next_term = TERM_NARROW;
		else if (!clk_valid)
			next_term = TERM_NONE;                                              // RL10
		else if (period <= TERM_NARROW_PER_MAX)
			next_term = TERM_NARROW;
		else if (period <= TERM_WIDE_PER_MAX)
			next_term = TERM_WIDE;
		else
			next_term = TERM_NONE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error counters and pattern generator per data lane

	wire prbs_on = cfg[CFG_PRBS] && (state == ST_ACTIVE) && clk_valid;           // RL21

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lane
			logic [7:0] err;
			logic [6:0] lfsr;
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					err  <= 8'h00;
					lfsr <= PRBS_SEED;
				end else if (i_ce) begin
					if (!en_s || i_err_clr)
						err <= 8'h00;
					else if (i_lane_err[g] && (state == ST_ACTIVE) && err != ERR_SAT)
						err <= err + 8'h01;                                      // RL20
					// Pattern steps on the input clock, so no clock means no pattern
					if (!prbs_on)
						lfsr <= PRBS_SEED ^ 7'(g);
					else if (lclk_rise)
						lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};                  // RL21
				end
			end
			assign o_err_cnt[8*g+7:8*g] = err;
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst)
					o_prbs_data[g] <= 1'b0;
				else if (i_ce)
					o_prbs_data[g] <= prbs_on & lfsr[6];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_state       <= ST_OFF;
			o_link_oe_n   <= 1'b1;
			o_power_down  <= 1'b1;
			o_standby     <= 1'b0;
			o_retimer     <= 1'b0;
			o_term_sel    <= TERM_NONE;
			o_eq_mode     <= EQ_FIXED_7P5DB;
			o_lane_src    <= MAP_NORMAL;
			o_pol_inv     <= 1'b0;
			o_ddc_fast    <= 1'b0;
			o_bus_addr    <= 2'h0;
			o_ratio_flag  <= 1'b0;
			o_clk_div40   <= 1'b0;
			o_prbs_active <= 1'b0;
		end else if (i_ce) begin
			o_state       <= state;
			o_link_oe_n   <= (state != ST_ACTIVE);                                // RL17
			o_power_down  <= (state == ST_OFF) || (state == ST_DOWN);
			o_standby     <= (state == ST_STANDBY);
			o_retimer     <= retimer_w;
			o_term_sel    <= next_term;
			o_eq_mode     <= next_eq;
			o_lane_src    <= next_src;
			o_pol_inv     <= next_pol;
			o_ddc_fast    <= cfg[CFG_DDC_FAST];                                  // RL7
			o_bus_addr    <= bus_addr;
			o_ratio_flag  <= ratio;
			o_clk_div40   <= ratio && (state == ST_ACTIVE) && retimer_w;          // RL4
			o_prbs_active <= prbs_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_disabled_two;
		(!en_s && i_ce) ##1 i_ce;
	endsequence

	sequence s_left_down;
		(state == ST_DOWN) ##1 (state != ST_DOWN && state != ST_OFF);
	endsequence

	sequence s_ratio_live;
		ratio && !i_ratio_clr && (state == ST_ACTIVE || state == ST_STANDBY);
	endsequence

	sequence s_no_input;
		state == ST_ACTIVE && standby_req && !pd_req && en_s && i_ce;
	endsequence

	a_off_hiz_out: assert property (s_disabled_two |=> (o_link_oe_n && o_power_down)) // RL17
		else $error("link not high impedance while disabled");

	a_cfg_wipe: assert property ((!en_s && i_ce) |=> (cfg == CFG_RST)) // RL3
		else $error("host settings survived disable");

	a_pd_bit: assert property ((state == ST_ACTIVE && cfg[CFG_PD] && en_s && i_ce) |=> (state == ST_DOWN)) // RL2
		else $error("power-down bit ignored");

	a_wake_only_ok: assert property (s_left_down |-> $past(hpd_s && !cfg[CFG_PD] && en_s)) // RL24
		else $error("left power-down without all conditions");

	a_ratio_hold: assert property (s_ratio_live |=> ratio) // RL5
		else $error("clock ratio flag lost without a clear");

	a_div40_gate: assert property (o_clk_div40 |-> (o_ratio_flag && o_retimer && o_state == ST_ACTIVE)) // RL4
		else $error("quarter-forty mode without flag");

	a_pol_retimer: assert property (o_pol_inv |-> o_retimer) // RL15
		else $error("polarity inversion in redriver operation");

	a_swap_map: assert property ((i_ce && live && swap_on) |=> (o_lane_src == MAP_SWAP)) // RL11
		else $error("swap routing wrong");

	a_adapt_retimer: assert property ((o_eq_mode == EQ_ADAPTIVE) |-> o_retimer) // RL9
		else $error("adaptive equalizer in redriver operation");

	a_enter_standby: assert property (s_no_input |=> (state == ST_STANDBY)) // RL6
		else $error("no standby without input clock");

	a_low_rate: assert property ((i_ce && !clk_valid) |=> !o_retimer) // RL1
		else $error("retimer without detected rate");

endmodule

// File: rtl/vrl_pkg.sv
// Constants, field positions and state codes for the video retimer lane control block.
// Assumes one 10 MHz system clock; pins arrive asynchronous and are synchronised in the top.
//
// Functional notes
// [RL1] Below the 1.0 Gbps rate run as redriver, above it as retimer.
// [RL2] Power down on hot-plug low, power-down config bit 3, or enable low.
// [RL3] Enable low clears every host-programmed setting; host must reprogram afterwards.
// [RL4] After re-enable or hot-plug return, quarter-forty clock waits for a flag write.
// [RL5] No read on the data channel clears the clock ratio flag.
// [RL6] With detection on, no input clock means standby; otherwise receiver stays powered.
// [RL7] Data channel runs 100 Kbps by default, 400 kbps when software selects.
// [RL8] With host configuration on, two address straps pick one of four addresses.
// [RL9] Equalizer from strap or host; adaptive allowed only in retimer operation.
// [RL10] Unconnected termination select picks termination from detected rate, wide above 2 Gbps; the code picks narrow above 3.4 Gbps.
// [RL11] Swap routes clock lane to data lane 2, lane 2 to clock, exchanges 1/0.
// [RL12] Swap on when swap strap low or config bit 7 set, in both operations.
// [RL13] Equalizer settings follow the swapped input pins; output assignment unchanged.
// [RL14] Polarity inversion from strap high or host bit, only in retimer operation.
// [RL15] Dropping to redriver on low rate removes any active polarity inversion.
// [RL16] Lane swap and polarity inversion may be active together in retimer operation.
// [RL17] Enable low: control inputs ignored, link inputs and outputs high impedance; equalizer and termination straps still set o_eq_mode and o_term_sel.
// [RL18] Controller holds enable low 100 us before asserting, after supply is valid.
// [RL19] Enable kept low until both rails stable removes any rail ordering need.
// [RL20] Per data lane approximate error count readable by host.
// [RL21] On request drive pseudo-random data outputs; needs input clock; eye data per lane.
// [RL22] Equalizer strap high gives 14 dB, low 7.5 dB, floating adaptive.
// [RL23] Signal detection off after reset; enabled by strap or host bit.
// [RL24] Leave power-down only with hot-plug high, power-down bit 0, enable high.

package vrl_pkg;

	localparam int CLK_HZ          = 10_000_000;
	// Missing-clock timeout before the input is judged absent
	localparam int SIG_TIMEOUT_NS  = 3200;
	localparam int SIG_TIMEOUT_CYC = (SIG_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;

	// Link clock period thresholds in system clocks (rate scaled for the sampled model)
	localparam logic [7:0] RETIMER_PER_MAX     = 8'h0a; // 1.0 Gbps
	localparam logic [7:0] TERM_WIDE_PER_MAX   = 8'h05; // 2 Gbps
	localparam logic [7:0] TERM_NARROW_PER_MAX = 8'h03; // 3.4 Gbps
	localparam logic [7:0] PER_SAT             = 8'hff;

	// Host configuration word bit positions
	localparam logic [7:0] CFG_RST        = 8'h00;
	localparam int         CFG_POL        = 0;
	localparam int         CFG_SIGDET     = 1;
	localparam int         CFG_DDC_FAST   = 2;
	localparam int         CFG_PD         = 3;
	localparam int         CFG_EQ_HOST    = 4;
	localparam int         CFG_EQ_ADAPT   = 5;
	localparam int         CFG_PRBS       = 6;
	localparam int         CFG_SWAP       = 7;

	// Synchroniser vector layout
	localparam int         SY_EN          = 0;
	localparam int         SY_HPD         = 1;
	localparam int         SY_SWAP        = 2;
	localparam int         SY_SIGDET      = 3;
	localparam int         SY_HOSTCFG     = 4;
	localparam int         SY_LCLK        = 5;
	localparam int         SY_EQ          = 6;
	localparam int         SY_TERM        = 8;
	localparam int         SY_ADDR        = 10;
	localparam int         SY_W           = 12;
	localparam logic [11:0] SY_RST        = 12'h000;

	// Three-level strap codes
	localparam logic [1:0] STRAP_LOW      = 2'h0;
	localparam logic [1:0] STRAP_HIGH     = 2'h1;
	localparam logic [1:0] STRAP_FLOAT    = 2'h2;

	// Equalizer modes
	localparam logic [1:0] EQ_FIXED_7P5DB = 2'h0;
	localparam logic [1:0] EQ_FIXED_14DB  = 2'h1;
	localparam logic [1:0] EQ_ADAPTIVE    = 2'h2;
	localparam logic [1:0] EQ_HOST_FIXED  = 2'h3;

	// Output termination
	localparam logic [1:0] TERM_NONE      = 2'h0;
	localparam logic [1:0] TERM_WIDE      = 2'h1;
	localparam logic [1:0] TERM_NARROW    = 2'h2;

	// Source input lane per output lane {clk, d2, d1, d0}; 0=d0 1=d1 2=d2 3=clk
	localparam logic [7:0] MAP_NORMAL     = 8'he4;
	localparam logic [7:0] MAP_SWAP       = 8'hb1;

	localparam logic [7:0] ERR_SAT        = 8'hff;
	localparam logic [6:0] PRBS_SEED      = 7'h7f;

	typedef enum logic [3:0] {
		ST_OFF     = 4'b0001,
		ST_DOWN    = 4'b0010,
		ST_STANDBY = 4'b0100,
		ST_ACTIVE  = 4'b1000
	} vrl_state_t;

endpackage

// File: sim/vrl_src_model.sv
// Far-side model of the upstream source: drives the input clock lane.
// Assumes the bench sets the half period in ns and starts or stops traffic with i_run.
`timescale 1ns/10ps

module vrl_src_model (
	// Control from the bench
	input  wire logic        i_run,
	input  wire logic [15:0] i_half_ns,
	// Input clock lane
	output logic             o_link_clk
);
	initial o_link_clk = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Odd start offset keeps the lane unrelated in phase to the system clock
	always begin
		#37;
		while (i_run) begin
			#(i_half_ns) o_link_clk = ~o_link_clk;
		end
		// Lane stands still outside traffic
		o_link_clk = 1'b0;
		@(i_run);
	end
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the video retimer lane control block.
// Assumes a 10 MHz system clock; inputs change on the falling edge, outputs are read there too.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module tb_top;
	import vrl_pkg::*;
	logic        i_clk, i_rst, i_dev_enable, i_hpd, i_swap_polarity_strap, i_signal_detect_enable;
	logic        i_host_cfg_en, i_link_clk, i_cfg_we, i_ratio_set, i_ratio_clr, i_err_clr;
	logic [1:0]  i_equalizer_select_strap, i_output_termination_select, i_bus_address_straps;
	logic [7:0]  i_cfg_wdata;
	logic [2:0]  i_lane_err;
	logic [3:0]  o_state;
	logic        o_link_oe_n, o_power_down, o_standby, o_retimer, o_pol_inv, o_ddc_fast;
	logic        o_ratio_flag, o_clk_div40, o_prbs_active;
	logic [1:0]  o_term_sel, o_eq_mode, o_bus_addr;
	logic [7:0]  o_lane_src;
	logic [23:0] o_err_cnt, exp_cnt;
	logic [2:0]  o_prbs_data;
	logic        run, i_ce;
	logic [2:0]  ones, zeros;
	logic [15:0] half_ns;
	logic [7:0]  w;
	logic [1:0]  addr;
	int          errors, samples_checked, seed_dummy;

	vrl_lane_ctrl vrl_lane_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_dev_enable(i_dev_enable),
		.i_hpd(i_hpd), .i_swap_polarity_strap(i_swap_polarity_strap),
		.i_signal_detect_enable(i_signal_detect_enable), .i_host_cfg_en(i_host_cfg_en),
		.i_link_clk(i_link_clk), .i_equalizer_select_strap(i_equalizer_select_strap),
		.i_output_termination_select(i_output_termination_select), .i_bus_address_straps(i_bus_address_straps),
		.i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata), .i_ratio_set(i_ratio_set), .i_ratio_clr(i_ratio_clr),
		.i_lane_err(i_lane_err), .i_err_clr(i_err_clr), .o_state(o_state), .o_link_oe_n(o_link_oe_n),
		.o_power_down(o_power_down), .o_standby(o_standby), .o_retimer(o_retimer), .o_term_sel(o_term_sel),
		.o_eq_mode(o_eq_mode), .o_lane_src(o_lane_src), .o_pol_inv(o_pol_inv), .o_ddc_fast(o_ddc_fast),
		.o_bus_addr(o_bus_addr), .o_ratio_flag(o_ratio_flag), .o_clk_div40(o_clk_div40),
		.o_err_cnt(o_err_cnt), .o_prbs_active(o_prbs_active), .o_prbs_data(o_prbs_data));

	vrl_src_model vrl_src_model_i (.i_run(run), .i_half_ns(half_ns), .o_link_clk(i_link_clk));

	initial i_clk = 1'b0;
	always #50 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Expected equalizer mode in retimer operation for a strap code and config word
	function automatic logic [1:0] exp_eq(input logic [1:0] s, input logic [7:0] cw);
		if (cw[CFG_EQ_HOST])
			return cw[CFG_EQ_ADAPT] ? EQ_ADAPTIVE : EQ_HOST_FIXED;
		return (s == STRAP_HIGH) ? EQ_FIXED_14DB : (s == STRAP_LOW) ? EQ_FIXED_7P5DB : EQ_ADAPTIVE;
	endfunction

	task automatic step(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Bounded wait for a power state; running out counts and ends the run
	task automatic wait_st(input logic [3:0] s);
		int k;
		k = 0;
		while (o_state !== s && k < 300) begin
			@(negedge i_clk);
			k++;
		end
		`CHK("state", s, o_state)
		if (o_state !== s)
			conclude();
		step(3);
	endtask

	task automatic write_cfg(input logic [7:0] cw);
		i_cfg_we = 1'b1;
		i_cfg_wdata = cw;
		step(1);
		i_cfg_we = 1'b0;
		step(4);
	endtask

	task automatic pulse(ref logic p);
		p = 1'b1;
		step(1);
		p = 1'b0;
		step(4);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed_dummy = $urandom(32'h201b8546);
		{i_rst, i_dev_enable, i_hpd, i_swap_polarity_strap, i_signal_detect_enable} = 5'b10010;
		{i_host_cfg_en, i_cfg_we, i_ratio_set, i_ratio_clr, i_err_clr} = 5'b10000;
		i_equalizer_select_strap = STRAP_FLOAT;
		i_output_termination_select = STRAP_FLOAT;
		addr = 2'($urandom);
		i_bus_address_straps = addr;
		i_cfg_wdata = 8'h00;
		i_lane_err = 3'h0;
		run = 1'b1;
		i_ce = 1'b1;
		half_ns = 16'h0190;
		errors = 0;
		samples_checked = 0;
		step(8);
		i_rst = 1'b0;
		// Enable stays low past the minimum hold before its first assertion
		step(1000);
		i_dev_enable = 1'b1;
		i_hpd = 1'b1;
		wait_st(ST_ACTIVE);
		step(40);
		`CHK("retimer", 1'b1, o_retimer)
		`CHK("oe_n", 1'b0, o_link_oe_n)
		`CHK("pol", 1'b1, o_pol_inv)
		`CHK("lanes", MAP_NORMAL, o_lane_src)
		`CHK("term", TERM_NONE, o_term_sel)
		`CHK("addr", addr, o_bus_addr)
		`CHK("ddc", 1'b0, o_ddc_fast)
		`CHK("div40", 1'b0, o_clk_div40)
		for (int s = 0; s < 3; s++) begin
			i_equalizer_select_strap = 2'(s);
			step(6);
			`CHK("eq strap", exp_eq(2'(s), 8'h00), o_eq_mode)
		end
		half_ns = 16'h00c8;
		step(40);
		`CHK("term wide", TERM_WIDE, o_term_sel)
		half_ns = 16'h0064;
		step(40);
		`CHK("term narrow", TERM_NARROW, o_term_sel)
		i_output_termination_select = STRAP_HIGH;
		step(6);
		`CHK("term strap high", TERM_NONE, o_term_sel)
		half_ns = 16'h0190;
		i_output_termination_select = STRAP_LOW;
		step(40);
		`CHK("term strap low", TERM_NARROW, o_term_sel)
		i_output_termination_select = STRAP_FLOAT;
		i_swap_polarity_strap = 1'b0;
		step(6);
		`CHK("swap strap", MAP_SWAP, o_lane_src)
		`CHK("pol off", 1'b0, o_pol_inv)
		i_swap_polarity_strap = 1'b1;
		// Corner words first, then random ones; power-down and detect bits kept clear
		for (int n = 0; n < 10; n++) begin
			w = (n < 4) ? ((n == 0) ? 8'h80 : (n == 1) ? 8'h10 : (n == 2) ? 8'h30 : 8'h44) : 8'($urandom) & 8'hf5;
			write_cfg(w);
			`CHK("lanes", w[CFG_SWAP] ? MAP_SWAP : MAP_NORMAL, o_lane_src)
			`CHK("pol", 1'b1, o_pol_inv)
			`CHK("eq", exp_eq(i_equalizer_select_strap, w), o_eq_mode)
			`CHK("ddc", w[CFG_DDC_FAST], o_ddc_fast)
			`CHK("pattern", w[CFG_PRBS], o_prbs_active)
		end
		// Equalizer follows the straps and config writes are ignored once host configuration is strapped off
		write_cfg(8'h10);
		i_host_cfg_en = 1'b0;
		step(6);
		`CHK("eq no host", exp_eq(i_equalizer_select_strap, 8'h00), o_eq_mode)
		write_cfg(8'h80);
		`CHK("lanes no host", MAP_NORMAL, o_lane_src)
		i_host_cfg_en = 1'b1;
		step(3);
		write_cfg(8'h00);
		pulse(i_ratio_set);
		`CHK("ratio", 1'b1, o_ratio_flag)
		`CHK("div40", 1'b1, o_clk_div40)
		pulse(i_ratio_clr);
		`CHK("ratio clr", 1'b0, o_ratio_flag)
		pulse(i_err_clr);
		exp_cnt = 24'h000000;
		for (int n = 0; n < 120; n++) begin
			i_lane_err = 3'($urandom);
			for (int g = 0; g < 3; g++)
				exp_cnt[8*g +: 8] += 8'(i_lane_err[g]);
			step(1);
		end
		i_lane_err = 3'h0;
		step(3);
		`CHK("err count", exp_cnt, o_err_cnt)
		i_lane_err = 3'h7;
		step(300);
		i_lane_err = 3'h0;
		step(2);
		`CHK("err saturate", 24'hffffff, o_err_cnt)
		pulse(i_err_clr);
		`CHK("err clear", 24'h000000, o_err_cnt)
		`CHK("pattern idle", 3'h0, o_prbs_data)
		write_cfg(8'h40);
		ones = 3'h0;
		zeros = 3'h0;
		for (int n = 0; n < 100; n++) begin
			ones |= o_prbs_data;
			zeros |= ~o_prbs_data;
			step(1);
		end
		`CHK("pattern ones", 3'h7, ones)
		`CHK("pattern zeros", 3'h7, zeros)
		write_cfg(8'h00);
		run = 1'b0;
		step(50);
		`CHK("redriver", 1'b0, o_retimer)
		`CHK("pol lost", 1'b0, o_pol_inv)
		`CHK("no standby", 1'b0, o_standby)
		`CHK("eq redriver", EQ_FIXED_14DB, o_eq_mode)
		write_cfg(8'h02);
		wait_st(ST_STANDBY);
		`CHK("standby", 1'b1, o_standby)
		run = 1'b1;
		wait_st(ST_ACTIVE);
		pulse(i_ratio_set);
		write_cfg(8'h08);
		wait_st(ST_DOWN);
		`CHK("pd", 1'b1, o_power_down)
		`CHK("oe_n pd", 1'b1, o_link_oe_n)
		write_cfg(8'h00);
		wait_st(ST_ACTIVE);
		step(40);
		`CHK("div40 wait", 1'b0, o_clk_div40)
		// A low clock enable freezes even the pin synchronisers
		i_ce = 1'b0;
		i_hpd = 1'b0;
		step(20);
		`CHK("ce hold", ST_ACTIVE, o_state)
		i_ce = 1'b1;
		wait_st(ST_DOWN);
		i_hpd = 1'b1;
		wait_st(ST_ACTIVE);
		write_cfg(8'h80);
		i_dev_enable = 1'b0;
		wait_st(ST_OFF);
		`CHK("oe_n off", 1'b1, o_link_oe_n)
		write_cfg(8'h08);
		addr = ~addr;
		i_bus_address_straps = addr;
		// Enable held low just past the minimum before it returns
		step(1000);
		i_dev_enable = 1'b1;
		wait_st(ST_ACTIVE);
		step(40);
		`CHK("cfg cleared", MAP_NORMAL, o_lane_src)
		`CHK("addr new", addr, o_bus_addr)
		conclude();
	end
endmodule
